//--- brfd_map.svh
`ifndef BRFD_MAP_SVH
`define BRFD_MAP_SVH

// ************************************************************
// register map (byte addresses)
// ************************************************************
`define BRFD_A_CTRL      8'h00
`define BRFD_A_STATUS    8'h04
`define BRFD_A_WREG      8'h08
`define BRFD_A_BSR       8'h0C
`define BRFD_A_PC        8'h10
`define BRFD_A_FSR2      8'h14
`define BRFD_A_INSTR     8'h18
`define BRFD_A_DADDR     8'h1C
`define BRFD_A_DDATA     8'h20

// ************************************************************
// fields and reset values
// ************************************************************
`define BRFD_CTRL_EXT    0
`define BRFD_FLAG_C      0
`define BRFD_FLAG_Z      2
`define BRFD_FLAG_N      4
`define BRFD_ST_BUSY     8
`define BRFD_ST_ILL      9
`define BRFD_RST_BYTE    8'h00
`define BRFD_RST_NIB     4'h0
`define BRFD_RST_PC      21'h000000
`define BRFD_RST_FSR     12'h000
`define BRFD_RST_INSTR   16'h0000

// ************************************************************
// encodings
// ************************************************************
`define BRFD_OPC_BCC     8'hE3
`define BRFD_OPC_BSC     8'hE7
`define BRFD_OPC_ROT     6'h10
`define BRFD_OPC_FILL    7'h34
`define BRFD_FILL_VAL    8'hFF
`define BRFD_ILO_MAX     8'h5F
`define BRFD_ACC_SPLIT   8'h60
`define BRFD_ACC_HI_BANK 4'hF
`define BRFD_PC_STEP     21'h000002

// ************************************************************
// timing
// ************************************************************
`define BRFD_Q_DIV_DEF   4
`define BRFD_Q_PER_CYC   3'h4
`define BRFD_DM_AW       12

`endif

//--- brfd_pkg.sv
package brfd_pkg;

	typedef logic [20:0] brfd_pc_t;
	typedef logic [11:0] brfd_daddr_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_Q1   = 6'b000010,
		ST_Q2   = 6'b000100,
		ST_Q3   = 6'b001000,
		ST_Q4   = 6'b010000,
		ST_NOP  = 6'b100000
	} brfd_state_e;

	typedef enum logic [4:0] {
		OP_NONE = 5'b00001,
		OP_BCC  = 5'b00010,
		OP_BSC  = 5'b00100,
		OP_ROT  = 5'b01000,
		OP_FILL = 5'b10000
	} brfd_op_e;

endpackage : brfd_pkg

//--- brfd_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface brfd_dec_if;
	import brfd_pkg::*;

	logic [15:0]  instr;
	logic [7:0]   status;
	logic [7:0]   operand;
	logic [3:0]   bank_select_register;
	brfd_daddr_t  fsr2;
	logic         ext_en;
	brfd_pc_t     pc;
	brfd_op_e     op;
	logic         dest_w;
	brfd_daddr_t  eff_addr;
	logic [7:0]   result;
	logic [7:0]   status_out;
	logic         take;
	brfd_pc_t     target;

	modport core (
		output instr, status, operand, bank_select_register, fsr2, ext_en, pc,
		input  op, dest_w, eff_addr, result, status_out, take, target
	);
	modport exec (
		input  instr, status, operand, bank_select_register, fsr2, ext_en, pc,
		output op, dest_w, eff_addr, result, status_out, take, target
	);

endinterface : brfd_dec_if

`default_nettype wire

//--- brfd_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "brfd_map.svh"

module brfd_exec (
	brfd_dec_if.exec dec       // decode request and answer
);
	import brfd_pkg::*;

	logic [7:0] f;
	logic       acc;

	assign f   = dec.instr[7:0];
	assign acc = dec.instr[8];

	// ************************************************************
	// opcode recognition
	// ************************************************************
	always_comb begin
		dec.op = OP_NONE;
		if (dec.instr[15:8] == `BRFD_OPC_BCC) begin
			dec.op = OP_BCC;
		end else if (dec.instr[15:8] == `BRFD_OPC_BSC) begin
			dec.op = OP_BSC;
		end else if (dec.instr[15:10] == `BRFD_OPC_ROT) begin
			dec.op = OP_ROT;
		end else if (dec.instr[15:9] == `BRFD_OPC_FILL) begin
			dec.op = OP_FILL;
		end
	end

	assign dec.dest_w = (dec.op == OP_ROT) && !dec.instr[9];

	// ************************************************************
	// effective file address
	// ************************************************************
	always_comb begin
		if (!acc && dec.ext_en && f <= `BRFD_ILO_MAX) begin
			dec.eff_addr = dec.fsr2 + {4'h0, f};
		end else if (!acc) begin
			// low part of the access bank maps to bank 0, the rest to the top bank
			dec.eff_addr = (f < `BRFD_ACC_SPLIT) ? {4'h0, f} : {`BRFD_ACC_HI_BANK, f};
		end else begin
			dec.eff_addr = {dec.bank_select_register, f};
		end
	end

	// ************************************************************
	// data path
	// ************************************************************
	always_comb begin
		dec.result     = dec.operand;
		dec.status_out = dec.status;
		unique case (dec.op)
			OP_ROT: begin
				dec.result = {dec.operand[0], dec.operand[7:1]};
				dec.status_out[`BRFD_FLAG_N] = dec.operand[0];
				dec.status_out[`BRFD_FLAG_Z] = (dec.operand == `BRFD_RST_BYTE);
			end
			OP_FILL: begin
				dec.result = `BRFD_FILL_VAL;
			end
			OP_NONE, OP_BCC, OP_BSC: begin
			end
		endcase
	end

	assign dec.take = ((dec.op == OP_BCC) && !dec.status[`BRFD_FLAG_C])
		|| ((dec.op == OP_BSC) && !dec.status[`BRFD_FLAG_N]);
	assign dec.target = dec.pc + `BRFD_PC_STEP + {{12{f[7]}}, f, 1'b0};

endmodule : brfd_exec

`default_nettype wire

//--- brfd_top.sv
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "brfd_map.svh"

module brfd_top #(
	parameter int Q_DIV = `BRFD_Q_DIV_DEF,  // clocks per quarter cycle
	parameter int DM_AW = `BRFD_DM_AW       // data memory address width
) (
	input  wire logic       mclk,        // core clock
	input  wire logic       rst,         // async reset, high
	input  wire logic       wb_cyc_i,    // bus cycle
	input  wire logic       wb_stb_i,    // strobe
	input  wire logic       wb_we_i,     // write enable
	input  wire logic [3:0] wb_sel_i,    // byte lanes
	input  wire logic [7:0] wb_adr_i,    // byte address
	input  wire logic [31:0] wb_dat_i,   // write data
	output logic            wb_ack_o,    // acknowledge
	output logic [31:0]     wb_dat_o,    // read data
	output logic            busy,        // instruction in flight
	output brfd_pkg::brfd_pc_t pc_o      // program counter
);
	import brfd_pkg::*;

	localparam int          DM_DEPTH = 1 << DM_AW;
	localparam logic [7:0]  QD_LAST  = 8'(Q_DIV - 1);

	brfd_dec_if dec ();

	brfd_state_e state;
	logic [7:0]  qcnt;
	logic        qtick;
	logic [2:0]  nop_cnt;
	logic        ext_en;
	logic [7:0]  status;
	logic        illegal;
	logic [7:0]  wreg;
	logic [3:0]  bank_select_register;
	brfd_pc_t    pc;
	brfd_daddr_t fsr2;
	logic [15:0] instr;
	brfd_daddr_t daddr;
	logic [7:0]  dmem [DM_DEPTH];
	brfd_op_e    op_r;
	logic        dest_w_r;
	brfd_daddr_t eff_r;
	logic [7:0]  operand_r;
	logic [7:0]  result_r;
	logic [7:0]  status_r;
	logic        take_r;
	brfd_pc_t    target_r;
	logic        wb_req;
	logic        wb_wr;
	logic [7:0]  wb_off;
	logic        idle;
	logic        start;
	logic        q4_end;
	logic [31:0] rd_mux;

	function automatic logic [31:0] wb_merge(
		input logic [31:0] old,
		input logic [31:0] din,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = din[8*i +: 8];
			end
		end
		return r;
	endfunction : wb_merge

	// ************************************************************
	// bus slave
	// ************************************************************
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_req && wb_we_i;
	assign wb_off = {wb_adr_i[7:2], 2'b00};
	assign idle   = (state == ST_IDLE);
	// software state other than CTRL and the illegal-flag clear is frozen while an instruction runs; such writes are acked and dropped
	assign start  = wb_wr && idle && (wb_off == `BRFD_A_INSTR) && wb_sel_i[0] && wb_sel_i[1];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (wb_off)
			`BRFD_A_CTRL:   rd_mux[`BRFD_CTRL_EXT] = ext_en;
			`BRFD_A_STATUS: rd_mux = {22'h000000, illegal, !idle, status};
			`BRFD_A_WREG:   rd_mux[7:0] = wreg;
			`BRFD_A_BSR:    rd_mux[3:0] = bank_select_register;
			`BRFD_A_PC:     rd_mux[20:0] = pc;
			`BRFD_A_FSR2:   rd_mux[11:0] = fsr2;
			`BRFD_A_INSTR:  rd_mux[15:0] = instr;
			`BRFD_A_DADDR:  rd_mux[11:0] = daddr;
			`BRFD_A_DDATA:  rd_mux[7:0] = dmem[daddr[DM_AW-1:0]];
			default:        rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h00000000;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= rd_mux;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_en <= 1'b0;
		end else if (wb_wr && wb_off == `BRFD_A_CTRL && wb_sel_i[0]) begin
			ext_en <= wb_dat_i[`BRFD_CTRL_EXT];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bank_select_register   <= `BRFD_RST_NIB;
			fsr2  <= `BRFD_RST_FSR;
			daddr <= `BRFD_RST_FSR;
			instr <= `BRFD_RST_INSTR;
		end else if (wb_wr && idle) begin
			unique case (wb_off)
				`BRFD_A_BSR:   if (wb_sel_i[0]) bank_select_register <= wb_dat_i[3:0];
				`BRFD_A_FSR2:  fsr2 <= 12'(wb_merge({20'h00000, fsr2}, wb_dat_i, wb_sel_i));
				`BRFD_A_DADDR: daddr <= 12'(wb_merge({20'h00000, daddr}, wb_dat_i, wb_sel_i));
				`BRFD_A_INSTR: if (start) instr <= wb_dat_i[15:0];
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// quarter-cycle divider
	// ************************************************************
	assign qtick = (qcnt == QD_LAST);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			qcnt <= 8'h00;
		end else if (start || qtick) begin
			qcnt <= 8'h00; // restart so the first quarter is a full one
		end else if (!idle) begin
			qcnt <= qcnt + 8'h01;
		end
	end

	// ************************************************************
	// quarter sequencer
	// ************************************************************
	assign q4_end = (state == ST_Q4) && qtick;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state   <= ST_IDLE;
			nop_cnt <= 3'h0;
		end else begin
			unique case (state)
				ST_IDLE: if (start) state <= ST_Q1;
				ST_Q1:   if (qtick) state <= ST_Q2;
				ST_Q2:   if (qtick) state <= ST_Q3;
				ST_Q3:   if (qtick) state <= ST_Q4;
				ST_Q4: begin
					if (qtick) begin
						state   <= take_r ? ST_NOP : ST_IDLE;
						nop_cnt <= 3'h0;
					end
				end
				ST_NOP: begin
					if (qtick) begin
						nop_cnt <= nop_cnt + 3'h1;
						if (nop_cnt == `BRFD_Q_PER_CYC - 3'h1) begin
							state <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else begin
			busy <= !idle || start;
		end
	end

	// ************************************************************
	// decode and execute
	// ************************************************************
	assign dec.instr   = instr;
	assign dec.status  = status;
	assign dec.operand = operand_r;
	assign dec.bank_select_register     = bank_select_register;
	assign dec.fsr2    = fsr2;
	assign dec.ext_en  = ext_en;
	assign dec.pc      = pc;

	brfd_exec u_exec (
		.dec (dec.exec)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			op_r     <= OP_NONE;
			dest_w_r <= 1'b0;
			eff_r    <= `BRFD_RST_FSR;
			take_r   <= 1'b0;
			target_r <= `BRFD_RST_PC;
		end else if (state == ST_Q1 && qtick) begin
			op_r     <= dec.op;
			dest_w_r <= dec.dest_w;
			eff_r    <= dec.eff_addr;
			take_r   <= dec.take;
			target_r <= dec.target;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			operand_r <= `BRFD_RST_BYTE;
		end else if (state == ST_Q2 && qtick) begin
			operand_r <= dmem[eff_r[DM_AW-1:0]];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			result_r <= `BRFD_RST_BYTE;
			status_r <= `BRFD_RST_BYTE;
		end else if (state == ST_Q3 && qtick) begin
			result_r <= dec.result;
			status_r <= dec.status_out;
		end
	end

	// ************************************************************
	// fourth-quarter writes
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (q4_end && (op_r == OP_FILL || (op_r == OP_ROT && !dest_w_r))) begin
			dmem[eff_r[DM_AW-1:0]] <= result_r;
		end else if (wb_wr && idle && wb_off == `BRFD_A_DDATA && wb_sel_i[0]) begin
			dmem[daddr[DM_AW-1:0]] <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wreg <= `BRFD_RST_BYTE;
		end else if (q4_end && op_r == OP_ROT && dest_w_r) begin
			wreg <= result_r;
		end else if (wb_wr && idle && wb_off == `BRFD_A_WREG && wb_sel_i[0]) begin
			wreg <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status <= `BRFD_RST_BYTE;
		end else if (q4_end && op_r == OP_ROT) begin
			status <= status_r;
		end else if (wb_wr && idle && wb_off == `BRFD_A_STATUS && wb_sel_i[0]) begin
			status <= wb_dat_i[7:0]; // branches and fill never touch flags
		end
	end

	// set wins over the software clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			illegal <= 1'b0;
		end else if (q4_end && op_r == OP_NONE) begin
			illegal <= 1'b1;
		end else if (wb_wr && wb_off == `BRFD_A_STATUS && wb_sel_i[1] && wb_dat_i[`BRFD_ST_ILL]) begin
			illegal <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc <= `BRFD_RST_PC;
		end else if (q4_end) begin
			pc <= take_r ? target_r : pc + `BRFD_PC_STEP;
		end else if (wb_wr && idle && wb_off == `BRFD_A_PC) begin
			pc <= 21'(wb_merge({11'h000, pc}, wb_dat_i, wb_sel_i));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_o <= `BRFD_RST_PC;
		end else if (q4_end) begin
			pc_o <= take_r ? target_r : pc + `BRFD_PC_STEP;
		end else if (wb_wr && idle && wb_off == `BRFD_A_PC) begin
			pc_o <= 21'(wb_merge({11'h000, pc}, wb_dat_i, wb_sel_i));
		end
	end

endmodule : brfd_top

`default_nettype wire

//--- brfd_top_unused_note_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- brfd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "brfd_map.svh"

module brfd_top_props #(
	parameter int Q_DIV = 4,	// clocks per quarter
	parameter int DM_AW = 12	// data memory address width
) (
	input wire logic               mclk,       // core clock
	input wire logic               rst,        // async reset
	input wire logic               wb_cyc_i,   // bus cycle
	input wire logic               wb_stb_i,   // strobe
	input wire logic               wb_we_i,    // write enable
	input wire logic [3:0]         wb_sel_i,   // byte lanes
	input wire logic [7:0]         wb_adr_i,   // byte address
	input wire logic [31:0]        wb_dat_i,   // write data
	input wire logic               wb_ack_o,   // acknowledge
	input wire logic [31:0]        wb_dat_o,   // read data
	input wire logic               busy,       // instruction in flight
	input wire brfd_pkg::brfd_pc_t pc_o        // program counter
);
	import brfd_pkg::*;

	// **********
	// helper logic
	// **********
	logic [7:0]  cnt;
	logic [20:0] cap_pc;
	logic [15:0] cap_ins;
	logic        req;
	logic        go;
	logic        br;
	logic [20:0] tgt;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign go  = req && wb_we_i && wb_adr_i[7:2] == 6'h06 && (&wb_sel_i[1:0]) && !busy;
	assign br  = cap_ins[15:8] == `BRFD_OPC_BCC || cap_ins[15:8] == `BRFD_OPC_BSC;
	assign tgt = cap_pc + 21'h2 + {{12{cap_ins[7]}}, cap_ins[7:0], 1'b0};

	// length of the current busy stretch, read at its falling edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cnt <= 8'h0;
		else
			cnt <= busy ? cnt + 8'h1 : 8'h0;
	end

	// the pc seen when the instruction was accepted is the base of every target
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cap_pc  <= 21'h0;
			cap_ins <= 16'h0;
		end else if (go) begin
			cap_pc  <= pc_o;
			cap_ins <= wb_dat_i[15:0];
		end
	end

	// **********
	// properties
	// **********
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence req_s;
		req;
	endsequence
	sequence go_s;
		go;
	endsequence
	sequence done_s;
		$fell(busy);
	endsequence

	a_ack_next: assert property (req_s |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_busy_start: assert property (go_s |-> ##[1:2] busy) else $error("no start");
	a_busy_len: assert property (done_s |-> cnt == 4*Q_DIV+1 || cnt == 8*Q_DIV+1)
		else $error("busy length wrong");
	a_pc_quiet: assert property (busy && cnt < 4*Q_DIV-1 |=> $stable(pc_o))
		else $error("pc moved before fourth quarter");
	a_pc_next: assert property (done_s |-> ((cnt == 8*Q_DIV+1) ? (br && pc_o == tgt)
		: (pc_o == cap_pc + 21'h2))) else $error("pc after instruction wrong");
	a_idle_pc: assert property (!busy && !(req && wb_we_i && wb_adr_i[7:2] == 6'h04)
		|=> $stable(pc_o)) else $error("pc moved while idle");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h08
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");

endmodule : brfd_top_props

bind brfd_top brfd_top_props #(.Q_DIV(Q_DIV), .DM_AW(DM_AW)) brfd_top_props_inst (
	.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .busy(busy), .pc_o(pc_o)
);

`default_nettype wire

//--- branch_rotate_fill_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none

module branch_rotate_fill_decode_tb;
	import brfd_pkg::*;

	// short quarters keep each instruction near 8 clocks, twice that for a taken branch
	localparam int QD = 2;

	typedef struct packed {
		logic        ext;
		logic [7:0]  st;
		logic [3:0]  bank_select_register;
		logic [11:0] fsr;
		logic [11:0] da;
		logic [7:0]  dv;
		logic [15:0] ins;
		logic        tk;
		logic [20:0] pc;
		logic [7:0]  est;
		logic [7:0]  ew;
		logic [7:0]  ed;
	} brfd_row_s;

	logic        mclk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [31:0] dat;
	logic        ack;
	logic [31:0] rdat;
	logic        busy;
	brfd_pc_t    pc;
	int          num_errors;
	int          samples_checked;
	int          ticks;
	int          n;
	logic [31:0] q;
	brfd_row_s   r;
	brfd_row_s   rows[12] = '{
		'{1'b0, 8'h00, 4'h0, 12'h0, 12'h0, 8'h00, 16'hE310, 1'b1, 21'h122, 8'h00, 8'h33, 8'h00},
		'{1'b0, 8'h01, 4'h0, 12'h0, 12'h0, 8'h00, 16'hE310, 1'b0, 21'h102, 8'h01, 8'h33, 8'h00},
		'{1'b0, 8'h00, 4'h0, 12'h0, 12'h0, 8'h00, 16'hE380, 1'b1, 21'h002, 8'h00, 8'h33, 8'h00},
		'{1'b0, 8'h01, 4'h0, 12'h0, 12'h0, 8'h00, 16'hE77F, 1'b1, 21'h200, 8'h01, 8'h33, 8'h00},
		'{1'b0, 8'h10, 4'h0, 12'h0, 12'h0, 8'h00, 16'hE77F, 1'b0, 21'h102, 8'h10, 8'h33, 8'h00},
		'{1'b0, 8'h01, 4'h2, 12'h0, 12'h245, 8'hD7, 16'h4345, 1'b0, 21'h102, 8'h11, 8'h33, 8'hEB},
		'{1'b0, 8'h14, 4'h3, 12'h0, 12'h310, 8'hD7, 16'h4110, 1'b0, 21'h102, 8'h10, 8'hEB, 8'hD7},
		'{1'b0, 8'h11, 4'h0, 12'h0, 12'hF80, 8'h00, 16'h4280, 1'b0, 21'h102, 8'h05, 8'h33, 8'h00},
		'{1'b1, 8'h00, 4'h0, 12'h300, 12'h320, 8'h02, 16'h4220, 1'b0, 21'h102, 8'h00, 8'h33, 8'h01},
		'{1'b0, 8'h15, 4'h5, 12'h0, 12'h55A, 8'h5A, 16'h695A, 1'b0, 21'h102, 8'h15, 8'h33, 8'hFF},
		'{1'b1, 8'h04, 4'h0, 12'h100, 12'h15F, 8'h00, 16'h685F, 1'b0, 21'h102, 8'h04, 8'h33, 8'hFF},
		'{1'b1, 8'h00, 4'h0, 12'h100, 12'hF60, 8'h00, 16'h6860, 1'b0, 21'h102, 8'h00, 8'h33, 8'hFF}
	};

	brfd_top #(.Q_DIV(QD)) brfd_top_inst (
		.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat), .busy(busy), .pc_o(pc)
	);

	// **********
	// tasks
	// **********
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			num_errors++;
		end
	endtask : chk

	// entered just after a rising edge; request held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (k >= 50)
			chk(32'h0, 32'h1);
		@(posedge mclk);
	endtask : wb

	task automatic wt();
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		// an instruction that never finishes counts as a mismatch
		if (n >= 100)
			chk(32'h0, 32'h1);
	endtask : wt

	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	always #2 mclk = ~mclk;

	always @(posedge mclk) begin
		ticks++;
		if (ticks == 20000) begin
			num_errors++;
			conclude();
		end
	end

	// **********
	// sequence
	// **********
	initial begin
		{mclk, cyc, stb, we, adr, dat, num_errors, samples_checked, ticks} = '0;
		sel = 4'hF;
		rst = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 12; i++) begin
			r = rows[i];
			wb(1'b1, 8'h00, {31'h0, r.ext});
			wb(1'b1, 8'h14, {20'h0, r.fsr});
			wb(1'b1, 8'h0C, {28'h0, r.bank_select_register});
			wb(1'b1, 8'h08, 32'h33);
			wb(1'b1, 8'h04, {24'h0, r.st});
			wb(1'b1, 8'h10, 32'h100);
			wb(1'b1, 8'h1C, {20'h0, r.da});
			wb(1'b1, 8'h20, {24'h0, r.dv});
			wb(1'b1, 8'h18, {16'h0, r.ins});
			wt();
			chk({31'h0, n > 4*QD+2}, {31'h0, r.tk});
			wb(1'b0, 8'h10, 32'h0);
			chk(q, {11'h0, r.pc});
			wb(1'b0, 8'h04, 32'h0);
			chk(q, {24'h0, r.est});
			wb(1'b0, 8'h08, 32'h0);
			chk(q, {24'h0, r.ew});
			wb(1'b0, 8'h20, 32'h0);
			chk(q, {24'h0, r.ed});
		end
		// a pc write landing mid-instruction must be dropped
		wb(1'b1, 8'h10, 32'h100);
		wb(1'b1, 8'h18, 32'h4345);
		wb(1'b1, 8'h10, 32'hAA);
		wt();
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h102);
		wb(1'b1, 8'h04, 32'h0);
		wb(1'b1, 8'h18, 32'hFFFF);
		wt();
		wb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h200);
		wb(1'b1, 8'h04, 32'h200);
		wb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		// reset in the middle of an instruction
		wb(1'b1, 8'h18, 32'hE310);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk({10'h0, busy, pc}, 32'h0);
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0);
		conclude();
	end

endmodule : branch_rotate_fill_decode_tb

`default_nettype wire
